// [aux_io_pkg.sv]
// Purpose : Shared constants for the camera auxiliary trigger and timing I/O block.
// Assumes : 50 MHz core clock.
// Notes   : Times are kept in their own unit; cycle counts derive from them.
package aux_io_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned ECHO_PULSE_NS   = 6_000;
    // Exact: 6 us at 20 ns is 300 cycles
    localparam int unsigned ECHO_CYCLES     = (ECHO_PULSE_NS * (CLK_HZ / 1_000_000)) / 1_000;
    localparam int unsigned ECHO_CNT_W      = 9;
    localparam logic [8:0]  ECHO_LAST       = 9'(ECHO_CYCLES - 1);
    localparam logic [8:0]  ECHO_CNT_RST    = 9'h000;

    // ----------------------------------------------------------------
    // Reset values and synchroniser depth
    // ----------------------------------------------------------------
    localparam logic        TRIG_IDLE_RST   = 1'b1;   // Idle trigger line reads high
    localparam int unsigned SYNC_STAGES     = 2;

endpackage

// [trig_fall_detect.sv]
// Purpose : Two-flop synchroniser with falling-edge detector for one trigger line.
// Assumes : Input is asynchronous to clk and idles high.
// Notes   : Emits a single-cycle pulse per high-to-low change.
`timescale 1ns/1ps

module trig_fall_detect (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Raw asynchronous line
    input  wire logic line_in,
    // Synchronised level and fall pulse
    output logic      level_out,
    output logic      fall_pulse
);

    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    logic nxt_meta;
    logic nxt_sync;
    logic nxt_prev;

    // ----------------------------------------------------------------
    // Synchroniser
    // ----------------------------------------------------------------
    // First stage feeds only the second stage
    always_comb begin
        nxt_meta = line_in;
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= aux_io_pkg::TRIG_IDLE_RST;
            sync_ff <= aux_io_pkg::TRIG_IDLE_RST;
            prev_ff <= aux_io_pkg::TRIG_IDLE_RST;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    // Idle-high reset means a line held low at reset still gives one fall
    assign level_out  = sync_ff;
    assign fall_pulse = prev_ff & ~sync_ff;

endmodule

// [aux_trigger_io.sv]
// Purpose : Auxiliary trigger inputs and timing outputs of a CCD camera.
// Assumes : Exposure and readout framing come from the sequencer on clk.
// Notes   : Echo pulse restarts if a new trigger lands while one is running.
`timescale 1ns/1ps

// Functional notes
// - Strobe high exactly while the sensor exposes in overlapped mode.
// - Falling edge on single-ended trigger starts an exposure.
// - Differential pair resolved; high-to-low change starts an exposure.
// - Line-valid high throughout each line's valid pixel period.
// - Line-valid low in gaps between lines.
// - Each external trigger gives one 6 us positive echo pulse; a trigger during a running pulse restarts it, giving one longer pulse.
// - Echo pulse begins at the same falling edge that started exposure.
// - Frame-valid high while active lines of a frame are output.
// - Frame-valid low between frames.
module aux_trigger_io (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // External trigger pins
    input  wire logic trig_in,
    input  wire logic trig_diff_p,
    input  wire logic trig_diff_n,
    // Sequencer status
    input  wire logic overlap_mode,
    input  wire logic sensor_exposing,
    input  wire logic line_pixels_valid,
    input  wire logic frame_lines_active,
    // Request to sequencer
    output logic      exposure_start,
    // Auxiliary outputs
    output logic      strobe_out,
    output logic      trigger_echo_out,
    output logic      line_valid_out,
    output logic      frame_valid_out
);

    logic        se_fall;
    logic        diff_fall;
    logic        diff_level;
    logic [8:0]  echo_cnt_ff;
    logic        echo_on_ff;
    logic        strobe_ff;
    logic        line_valid_out_ff;
    logic        fval_ff;
    logic [8:0]  nxt_echo_cnt;
    logic        nxt_echo_on;
    logic        nxt_strobe;
    logic        nxt_line_valid_out;
    logic        nxt_fval;
    // Checker-only age counter, kept apart from the echo counter it watches
    logic [9:0]  chk_age_ff;
    logic [9:0]  nxt_chk_age;

    // ----------------------------------------------------------------
    // Trigger inputs
    // ----------------------------------------------------------------
    // Pair resolved to one level; the receiver answer is then synchronised like trig_in
    trig_fall_detect u_se (
        .clk        (clk),
        .rst_n      (rst_n),
        .line_in    (trig_in),
        .level_out  (),
        .fall_pulse (se_fall)
    );

    trig_fall_detect u_diff (
        .clk        (clk),
        .rst_n      (rst_n),
        .line_in    (trig_diff_p & ~trig_diff_n),
        .level_out  (diff_level),
        .fall_pulse (diff_fall)
    );

    // Either source starts one exposure
    assign exposure_start = se_fall | diff_fall;

    // ----------------------------------------------------------------
    // Echo pulse and framing outputs
    // ----------------------------------------------------------------
    // Echo rises on the cycle after the detected fall, lasts ECHO_CYCLES
    always_comb begin
        nxt_echo_on  = echo_on_ff;
        nxt_echo_cnt = echo_cnt_ff;
        if (exposure_start) begin
            nxt_echo_on  = 1'b1;
            nxt_echo_cnt = aux_io_pkg::ECHO_CNT_RST;
        end else if (echo_on_ff) begin
            if (echo_cnt_ff == aux_io_pkg::ECHO_LAST) begin
                nxt_echo_on = 1'b0;
            end else begin
                nxt_echo_cnt = echo_cnt_ff + 9'h001;
            end
        end
        nxt_strobe = overlap_mode & sensor_exposing;
        nxt_line_valid_out   = line_pixels_valid;
        nxt_fval   = frame_lines_active;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            echo_on_ff  <= 1'b0;
            echo_cnt_ff <= aux_io_pkg::ECHO_CNT_RST;
            strobe_ff   <= 1'b0;
            line_valid_out_ff     <= 1'b0;
            fval_ff     <= 1'b0;
        end else begin
            echo_on_ff  <= nxt_echo_on;
            echo_cnt_ff <= nxt_echo_cnt;
            strobe_ff   <= nxt_strobe;
            line_valid_out_ff     <= nxt_line_valid_out;
            fval_ff     <= nxt_fval;
        end
    end

    assign trigger_echo_out = echo_on_ff;
    assign strobe_out       = strobe_ff;
    assign line_valid_out   = line_valid_out_ff;
    assign frame_valid_out  = fval_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Cycles since the last start, saturating; zero means none since reset.
    // Counting here lets a retrigger mid-pulse be checked without long repeats.
    always_comb begin
        nxt_chk_age = chk_age_ff;
        if (exposure_start) begin
            nxt_chk_age = 10'h001;
        end else if (chk_age_ff != 10'h000 && chk_age_ff != 10'h3ff) begin
            nxt_chk_age = chk_age_ff + 10'h001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_age_ff <= 10'h000;
        end else begin
            chk_age_ff <= nxt_chk_age;
        end
    end

    property p_strobe_follows;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> (strobe_out == $past(overlap_mode & sensor_exposing));
    endproperty
    a_strobe_follows: assert property (p_strobe_follows) else $error("strobe not tied to exposure");

    property p_se_start;
        @(posedge clk) disable iff (!rst_n)
        se_fall |-> exposure_start;
    endproperty
    a_se_start: assert property (p_se_start) else $error("single-ended fall lost");

    property p_diff_start;
        @(posedge clk) disable iff (!rst_n)
        (diff_level == 1'b0 && $past(diff_level) == 1'b1) |-> exposure_start;
    endproperty
    a_diff_start: assert property (p_diff_start) else $error("differential fall lost");

    property p_line_valid_out_high;
        @(posedge clk) disable iff (!rst_n)
        line_pixels_valid |=> line_valid_out;
    endproperty
    a_line_valid_out_high: assert property (p_line_valid_out_high) else $error("line valid missing");

    property p_line_valid_out_low;
        @(posedge clk) disable iff (!rst_n)
        !line_pixels_valid |=> !line_valid_out;
    endproperty
    a_line_valid_out_low: assert property (p_line_valid_out_low) else $error("line valid in gap");

    property p_echo_width;
        @(posedge clk) disable iff (!rst_n)
        trigger_echo_out == (chk_age_ff != 10'h000 && chk_age_ff <= 10'(aux_io_pkg::ECHO_CYCLES));
    endproperty
    a_echo_width: assert property (p_echo_width) else $error("echo pulse width wrong");

    property p_echo_start;
        @(posedge clk) disable iff (!rst_n)
        exposure_start |=> (trigger_echo_out && echo_cnt_ff == 9'h000);
    endproperty
    a_echo_start: assert property (p_echo_start) else $error("echo not started at trigger");

    property p_fval_high;
        @(posedge clk) disable iff (!rst_n)
        frame_lines_active |=> frame_valid_out;
    endproperty
    a_fval_high: assert property (p_fval_high) else $error("frame valid missing");

    property p_fval_low;
        @(posedge clk) disable iff (!rst_n)
        !frame_lines_active |=> !frame_valid_out;
    endproperty
    a_fval_low: assert property (p_fval_low) else $error("frame valid between frames");

    property p_single_act;
        @(posedge clk) disable iff (!rst_n)
        se_fall |=> !se_fall;
    endproperty
    a_single_act: assert property (p_single_act) else $error("one fall acted twice");

    property p_cov_se;
        @(posedge clk) disable iff (!rst_n) se_fall ##1 trigger_echo_out;
    endproperty
    c_cov_se: cover property (p_cov_se);

    property p_cov_diff;
        @(posedge clk) disable iff (!rst_n) diff_fall;
    endproperty
    c_cov_diff: cover property (p_cov_diff);

    property p_cov_retrig;
        @(posedge clk) disable iff (!rst_n) echo_on_ff && exposure_start;
    endproperty
    c_cov_retrig: cover property (p_cov_retrig);

    property p_cov_strobe;
        @(posedge clk) disable iff (!rst_n) $rose(strobe_out);
    endproperty
    c_cov_strobe: cover property (p_cov_strobe);

endmodule

// [trig_source_model.sv]
// Purpose : Far-side trigger source driving the camera trigger pins.
// Assumes : The bench requests one fall at a time, off the sampling edge.
// Notes   : trig_in and trig_diff_p idle high, trig_diff_n low; a fall stays low for low_len cycles, then releases.
`timescale 1ns/1ps

module trig_source_model (
    // Clock
    input  wire logic       clk,
    // Requests from the bench
    input  wire logic       fire_se,
    input  wire logic       fire_diff,
    input  wire logic [7:0] low_len,
    // Trigger pins
    output logic            trig_in,
    output logic            trig_diff_p,
    output logic            trig_diff_n
);
    logic [7:0] se_cnt = 8'h00;
    logic [7:0] df_cnt = 8'h00;

    // Low spans are counted so a long hold still reads as one fall
    always @(posedge clk) begin
        if (fire_se) se_cnt <= low_len;
        else if (se_cnt != 8'h00) se_cnt <= se_cnt - 8'h01;
        if (fire_diff) df_cnt <= low_len;
        else if (df_cnt != 8'h00) df_cnt <= df_cnt - 8'h01;
    end

    // trig_in and trig_diff_p idle high between triggers (trig_diff_n low), one clean fall per request
    assign trig_in     = (se_cnt == 8'h00);
    assign trig_diff_p = (df_cnt == 8'h00);
    assign trig_diff_n = (df_cnt != 8'h00);
endmodule

// [camera_aux_trigger_sync_io_test.sv]
// Purpose : Self-checking bench for the aux trigger and framing outputs.
// Assumes : 50 MHz clock; inputs change 2 ns after the rising edge.
// Notes   : Random framing and low spans from a fixed seed.
`timescale 1ns/1ps

module camera_aux_trigger_sync_io_test;
    logic       clk, rst_n, overlap_mode, sensor_exposing, line_pixels_valid, frame_lines_active;
    logic       fire_se, fire_diff, exposure_start, strobe_out, trigger_echo_out;
    logic       line_valid_out, frame_valid_out, trig_in, trig_diff_p, trig_diff_n;
    logic [7:0] low_len;
    int         n_fail, compares, seed;

    aux_trigger_io i_dut (.clk(clk), .rst_n(rst_n), .trig_in(trig_in), .trig_diff_p(trig_diff_p),
        .trig_diff_n(trig_diff_n), .overlap_mode(overlap_mode), .sensor_exposing(sensor_exposing),
        .line_pixels_valid(line_pixels_valid), .frame_lines_active(frame_lines_active),
        .exposure_start(exposure_start), .strobe_out(strobe_out), .trigger_echo_out(trigger_echo_out),
        .line_valid_out(line_valid_out), .frame_valid_out(frame_valid_out));
    trig_source_model i_src (.clk(clk), .fire_se(fire_se), .fire_diff(fire_diff), .low_len(low_len),
        .trig_in(trig_in), .trig_diff_p(trig_diff_p), .trig_diff_n(trig_diff_n));

    // 20 ns clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Expected strobe level from the mode and exposure inputs
    function automatic logic exp_strobe(input logic [3:0] lv);
        return lv[3] & lv[2];
    endfunction

    // Random framing levels; line and frame valid copy their input, strobe the AND of mode and exposure, one cycle late
    task automatic framing(input int n);
        logic [3:0] v;
        for (int i = 0; i < n; i++) begin
            v = 4'($random(seed));
            {overlap_mode, sensor_exposing, line_pixels_valid, frame_lines_active} = v;
            @(posedge clk);
            #2;
            check(32'(strobe_out), 32'(exp_strobe(v)));
            check(32'(line_valid_out), 32'(v[1]));
            check(32'(frame_valid_out), 32'(v[0]));
        end
    endtask

    // One fall (or two when gap is set); counts starts and echo width after the last
    task automatic trig(input logic [1:0] sel, input int starts, input int gap);
        int run, ns, first;
        logic prev;
        run = 0; ns = 0; first = 0; prev = 1'b0;
        low_len = 8'h03 + 8'($unsigned($random(seed)) % 18);
        {fire_diff, fire_se} = sel;
        @(posedge clk);
        #2;
        for (int i = 0; i < 700; i++) begin
            {fire_diff, fire_se} = (i == gap) ? sel : 2'b00;
            @(posedge clk);
            #2;
            if (prev) check(32'(trigger_echo_out), 32'h1);
            if (exposure_start) begin
                ns++;
                run = 0;
                if (ns == 1) first = i;
            end else if (trigger_echo_out) run++;
            prev = exposure_start;
        end
        check(32'(first >= 1 && first <= 3), 32'h1);
        check(32'(ns), 32'(starts));
        check(32'(run), 32'd300);
        $display("trigger test sel=%h done", sel);
    endtask

    // Hang guard
    initial begin
        #1ms;
        n_fail++;
        complete_run();
    end

    initial begin
        seed = 32'hb6b0f266;
        n_fail = 0; compares = 0; rst_n = 1'b0; fire_se = 1'b0; fire_diff = 1'b0; low_len = 8'h04;
        {overlap_mode, sensor_exposing, line_pixels_valid, frame_lines_active} = 4'hf;
        repeat (16) @(posedge clk);
        #2;
        check({28'h0, strobe_out, trigger_echo_out, line_valid_out, frame_valid_out}, 32'h0);
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #2;
        framing(80);
        $display("framing test done");
        {overlap_mode, sensor_exposing, line_pixels_valid, frame_lines_active} = 4'h0;
        trig(2'b01, 1, -1);
        trig(2'b10, 1, -1);
        trig(2'b11, 1, -1);
        trig(2'b01, 2, 100);
        trig(2'b10, 2, 250);
        complete_run();
    end
endmodule
